// >>> chd_pkg.sv
// Shared constants and types of the host command decoder.
// Assumes it is compiled before every other file of the decoder.
package chd_pkg;

  // ----------------------------------------------------------------------
  // Command byte layout
  // ----------------------------------------------------------------------
  localparam int unsigned CMD_RW_BIT   = 7;
  localparam int unsigned CMD_TYPE_HI  = 6;
  localparam int unsigned CMD_TYPE_LO  = 5;
  localparam int unsigned CMD_MEM_SEL  = 4;
  localparam logic [1:0]  TYPE_LOCAL   = 2'h0;
  localparam logic [1:0]  TYPE_GLOBAL  = 2'h1;
  localparam logic [1:0]  TYPE_BAD     = 2'h2;
  localparam logic [1:0]  TYPE_MEM     = 2'h3;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  localparam logic [4:0]  CHAN_EN_ADDR = 5'h05;
  localparam logic [7:0]  CHAN_EN_RST  = 8'h00;
  localparam logic [1:0]  LAST_REG_LSB = 2'h0;
  // Identification byte; the value is arbitrary.
  localparam logic [7:0]  ID_CODE      = 8'h5a;

  // ----------------------------------------------------------------------
  // Memories
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_CH       = 4;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned COEF_W       = 14;
  localparam int unsigned COEF_DROP    = 2;
  localparam int unsigned COEF_WORDS   = 40;
  localparam int unsigned COEF_AW      = 6;
  localparam logic [3:0]  COEF_BLOCKS  = 4'h5;
  localparam int unsigned FSK_WORDS    = 32;
  localparam int unsigned FSK_AW       = 5;
  localparam logic [2:0]  BLK_TOP_WORD = 3'h7;

  typedef enum logic [1:0] {ST_IDLE, ST_REG, ST_MEM, ST_DISCARD} chd_state_e;

endpackage

// >>> chd_word_mem.sv
// Word-wide storage with a clocked write port and an asynchronous read port.
// Assumes the caller keeps both addresses inside DEPTH.
`timescale 1ns/1ps
module chd_word_mem #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW    = 5,
  parameter int unsigned W     = 16
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [W-1:0]  wrData,
  // Read port
  input  wire logic [AW-1:0] rdAddr,
  output logic      [W-1:0]  rdData
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  assign rdData = mem[rdAddr];

endmodule // chd_word_mem

// >>> chd_chan_pick.sv
// Picks the lowest enabled channel for single-channel reads.
// Assumes a four-bit enable vector, channel one in bit 0.
`timescale 1ns/1ps
module chd_chan_pick (
  // Enables
  input  wire logic [3:0] enable,
  // Choice
  output logic      [3:0] oneHot,
  output logic      [1:0] index
);

  always_comb begin
    oneHot = 4'h0;
    index  = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (enable[i]) begin
        oneHot = 4'h0;
        oneHot[i] = 1'b1;
        index  = 2'(i);
      end
    end
  end

endmodule // chd_chan_pick

// >>> chd_host_command_decoder.sv
// Command decoder of the host control port: registers, coefficient memories
// and the shared caller-ID buffer, reached by one byte per strobe.
// Assumes a serialiser outside delivers byte slots while chip select is low.
`timescale 1ns/1ps
module chd_host_command_decoder (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Byte slots of the host control port
  input  wire logic       csN,
  input  wire logic       byteStrobe,
  input  wire logic [7:0] byteIn,
  output logic      [7:0] txByte,
  // Register write side
  output logic            regWrStrobe,
  output logic            regWrGlobal,
  output logic      [3:0] regWrChan,
  output logic      [4:0] regWrAddr,
  output logic      [7:0] regWrData,
  // Register read side
  output logic      [4:0] regRdAddr,
  output logic            regRdGlobal,
  output logic      [3:0] regRdChan,
  input  wire logic [7:0] regRdData,
  // Status
  output logic      [3:0] chanEnable,
  output logic            cmdRefused
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  chd_pkg::chd_state_e state_ff;
  logic [4:0] addr_ff;
  logic [3:0] blk_ff;
  logic [2:0] word_ff;
  logic       phase_ff;
  logic       idPending_ff;
  logic       isWrite_ff;
  logic       isGlobal_ff;
  logic       isFsk_ff;
  logic [7:0] hiByte_ff;
  logic       loadTx_ff;
  logic [7:0] txByte_ff;
  logic [7:0] chanEn_ff;
  logic       regWrStrobe_ff;
  logic       regWrGlobal_ff;
  logic [3:0] regWrChan_ff;
  logic [4:0] regWrAddr_ff;
  logic [7:0] regWrData_ff;
  logic [3:0] regRdChan_ff;
  logic       cmdRefused_ff;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  logic       slot;
  logic       cmdTake;
  logic       cmdWrite;
  logic [1:0] cmdType;
  logic       cmdFsk;
  logic       cmdMemOk;
  logic       cmdOk;

  assign slot     = byteStrobe && !csN;
  assign cmdTake  = slot && (state_ff == chd_pkg::ST_IDLE);
  assign cmdWrite = byteIn[chd_pkg::CMD_RW_BIT];
  assign cmdType  = byteIn[chd_pkg::CMD_TYPE_HI:chd_pkg::CMD_TYPE_LO];
  assign cmdFsk   = byteIn[chd_pkg::CMD_MEM_SEL];

  // Blocks outside the memories are refused like the prohibited type.
  always_comb begin
    if (cmdFsk) begin
      cmdMemOk = (byteIn[3:2] == 2'h0);
    end else begin
      cmdMemOk = (byteIn[3:0] < chd_pkg::COEF_BLOCKS);
    end
  end

  assign cmdOk = (cmdType != chd_pkg::TYPE_BAD)
                 && ((cmdType != chd_pkg::TYPE_MEM) || cmdMemOk);

  // ----------------------------------------------------------------------
  // Data slot steps
  // ----------------------------------------------------------------------
  logic regStep;
  logic regLast;
  logic memStep;
  logic memLast;
  logic idSlot;
  logic chanEnHit;

  assign idSlot  = slot && !isWrite_ff && idPending_ff;
  assign regStep = slot && (state_ff == chd_pkg::ST_REG) && !idSlot;
  assign regLast = regStep && (addr_ff[1:0] == chd_pkg::LAST_REG_LSB);
  assign memStep = slot && (state_ff == chd_pkg::ST_MEM) && !idSlot;
  assign memLast = memStep && phase_ff && (word_ff == 3'h0);
  assign chanEnHit = isGlobal_ff && (addr_ff == chd_pkg::CHAN_EN_ADDR);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= chd_pkg::ST_IDLE;
    end else if (csN) begin
      state_ff <= chd_pkg::ST_IDLE;
    end else if (slot) begin
      unique case (state_ff)
        chd_pkg::ST_IDLE: begin
          if (!cmdOk) begin
            state_ff <= chd_pkg::ST_DISCARD;
          end else if (cmdType == chd_pkg::TYPE_MEM) begin
            state_ff <= chd_pkg::ST_MEM;
          end else begin
            state_ff <= chd_pkg::ST_REG;
          end
        end
        chd_pkg::ST_REG: begin
          if (regLast) begin
            state_ff <= chd_pkg::ST_DISCARD;
          end
        end
        chd_pkg::ST_MEM: begin
          if (memLast) begin
            state_ff <= chd_pkg::ST_DISCARD;
          end
        end
        chd_pkg::ST_DISCARD: begin
          state_ff <= chd_pkg::ST_DISCARD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Transfer pointers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff      <= 5'h00;
      blk_ff       <= 4'h0;
      word_ff      <= 3'h0;
      phase_ff     <= 1'b0;
      idPending_ff <= 1'b0;
      isWrite_ff   <= 1'b0;
      isGlobal_ff  <= 1'b0;
      isFsk_ff     <= 1'b0;
    end else if (cmdTake) begin
      addr_ff      <= byteIn[4:0];
      blk_ff       <= byteIn[3:0];
      word_ff      <= chd_pkg::BLK_TOP_WORD;
      phase_ff     <= 1'b0;
      idPending_ff <= !cmdWrite;
      isWrite_ff   <= cmdWrite;
      isGlobal_ff  <= (cmdType == chd_pkg::TYPE_GLOBAL);
      isFsk_ff     <= cmdFsk;
    end else begin
      if (idSlot) begin
        idPending_ff <= 1'b0;
      end
      if (regStep && !regLast) begin
        addr_ff <= addr_ff - 5'h01;
      end
      if (memStep) begin
        phase_ff <= !phase_ff;
        if (phase_ff) begin
          word_ff <= word_ff - 3'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Channel enable register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chanEn_ff <= chd_pkg::CHAN_EN_RST;
    end else if (regStep && isWrite_ff && chanEnHit) begin
      chanEn_ff <= byteIn;
    end
  end

  logic [3:0] pickOneHot;
  logic [1:0] pickIdx;

  chd_chan_pick u_pick (
    .enable (chanEn_ff[3:0]),
    .oneHot (pickOneHot),
    .index  (pickIdx)
  );

  // ----------------------------------------------------------------------
  // Register write strobe and read channel
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regWrStrobe_ff <= 1'b0;
      regWrGlobal_ff <= 1'b0;
      regWrChan_ff   <= 4'h0;
      regWrAddr_ff   <= 5'h00;
      regWrData_ff   <= 8'h00;
      regRdChan_ff   <= 4'h0;
    end else begin
      // Each completed byte but the channel enable one is written at once, a local one only while a channel is enabled, so an abort leaves it in place.
      regWrStrobe_ff <= regStep && isWrite_ff && !chanEnHit
                        && (isGlobal_ff || (chanEn_ff[3:0] != 4'h0));
      regRdChan_ff   <= pickOneHot;
      if (regStep && isWrite_ff) begin
        regWrGlobal_ff <= isGlobal_ff;
        regWrChan_ff   <= isGlobal_ff ? 4'h0 : chanEn_ff[3:0];
        regWrAddr_ff   <= addr_ff;
        regWrData_ff   <= byteIn;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Coefficient memories and caller-ID buffer
  // ----------------------------------------------------------------------
  logic [chd_pkg::COEF_AW-1:0] coefAddr;
  logic [chd_pkg::FSK_AW-1:0]  fskAddr;
  logic [15:0]                 wrWord;
  logic                        wordDone;
  logic [chd_pkg::COEF_W-1:0]  coefRd [chd_pkg::NUM_CH];
  logic [15:0]                 fskRd;
  logic [15:0]                 rdWord;

  assign coefAddr = {blk_ff[2:0], word_ff};
  assign fskAddr  = {blk_ff[1:0], word_ff};
  assign wrWord   = {hiByte_ff, byteIn};
  assign wordDone = memStep && isWrite_ff && phase_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hiByte_ff <= 8'h00;
    end else if (memStep && isWrite_ff && !phase_ff) begin
      hiByte_ff <= byteIn;
    end
  end

  for (genvar ch = 0; ch < chd_pkg::NUM_CH; ch++) begin : g_coef
    chd_word_mem #(
      .DEPTH (chd_pkg::COEF_WORDS),
      .AW    (chd_pkg::COEF_AW),
      .W     (chd_pkg::COEF_W)
    ) u_coef (
      .clk    (clk),
      .wrEn   (wordDone && !isFsk_ff && chanEn_ff[ch]),
      .wrAddr (coefAddr),
      .wrData (wrWord[15:chd_pkg::COEF_DROP]),
      .rdAddr (coefAddr),
      .rdData (coefRd[ch])
    );
  end

  chd_word_mem #(
    .DEPTH (chd_pkg::FSK_WORDS),
    .AW    (chd_pkg::FSK_AW),
    .W     (chd_pkg::WORD_W)
  ) u_fsk (
    .clk    (clk),
    .wrEn   (wordDone && isFsk_ff),
    .wrAddr (fskAddr),
    .wrData (wrWord),
    .rdAddr (fskAddr),
    .rdData (fskRd)
  );

  always_comb begin
    if (isFsk_ff) begin
      rdWord = fskRd;
    end else if (chanEn_ff[3:0] == 4'h0) begin
      rdWord = 16'h0000;
    end else begin
      rdWord = {coefRd[pickIdx], 2'h0};
    end
  end

  // ----------------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------------
  logic [7:0] txSource;

  always_comb begin
    unique case (state_ff)
      chd_pkg::ST_REG: begin
        txSource = chanEnHit ? chanEn_ff : regRdData;
      end
      chd_pkg::ST_MEM: begin
        txSource = phase_ff ? rdWord[7:0] : rdWord[15:8];
      end
      chd_pkg::ST_IDLE,
      chd_pkg::ST_DISCARD: begin
        txSource = 8'h00;
      end
    endcase
  end

  // The next byte is fetched one cycle after the slot, once pointers have moved.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loadTx_ff <= 1'b0;
      txByte_ff <= 8'h00;
    end else if (csN) begin
      loadTx_ff <= 1'b0;
      txByte_ff <= 8'h00;
    end else begin
      loadTx_ff <= slot && !isWrite_ff
                   && ((state_ff == chd_pkg::ST_REG) || (state_ff == chd_pkg::ST_MEM));
      if (cmdTake && cmdOk && !cmdWrite) begin
        txByte_ff <= chd_pkg::ID_CODE;
      end else if (loadTx_ff) begin
        txByte_ff <= txSource;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdRefused_ff <= 1'b0;
    end else begin
      cmdRefused_ff <= cmdTake && !cmdOk;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign txByte      = txByte_ff;
  assign regWrStrobe = regWrStrobe_ff;
  assign regWrGlobal = regWrGlobal_ff;
  assign regWrChan   = regWrChan_ff;
  assign regWrAddr   = regWrAddr_ff;
  assign regWrData   = regWrData_ff;
  assign regRdAddr   = addr_ff;
  assign regRdGlobal = isGlobal_ff;
  assign regRdChan   = regRdChan_ff;
  assign chanEnable  = chanEn_ff[3:0];
  assign cmdRefused  = cmdRefused_ff;

endmodule // chd_host_command_decoder

// >>> chd_host_chk.sv
// Concurrent checks on the ports of the host command decoder.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module chd_host_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Host port
  input wire logic       csN,
  input wire logic       byteStrobe,
  input wire logic [7:0] byteIn,
  input wire logic [7:0] txByte,
  // Register side and status
  input wire logic       regWrStrobe,
  input wire logic       regWrGlobal,
  input wire logic [3:0] regWrChan,
  input wire logic [4:0] regWrAddr,
  input wire logic [3:0] chanEnable,
  input wire logic       cmdRefused
);
  logic       firstSlot_ff;
  logic       lastOk_ff;
  logic [4:0] lastAddr_ff;
  logic       cmdTaken;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  assign cmdTaken = byteStrobe && !csN && firstSlot_ff;

  // Marks the command slot of each frame.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) firstSlot_ff <= 1'b1;
    else if (csN) firstSlot_ff <= 1'b1;
    else if (byteStrobe) firstSlot_ff <= 1'b0;
  end

  // Remembers the last register written within the current frame.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lastOk_ff <= 1'b0;
    else if (csN || cmdTaken) lastOk_ff <= 1'b0;
    else if (regWrStrobe) lastOk_ff <= 1'b1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lastAddr_ff <= 5'h00;
    else if (regWrStrobe) lastAddr_ff <= regWrAddr;
  end

  read_id_a: assert property (
    cmdTaken && !byteIn[7] && !byteIn[6] |=> txByte == chd_pkg::ID_CODE)
    else $error("no identification byte after a read command");
  bad_type_a: assert property (
    cmdTaken && byteIn[6:5] == chd_pkg::TYPE_BAD |=> cmdRefused)
    else $error("prohibited command type not refused");
  refuse_cause_a: assert property (cmdRefused |-> $past(cmdTaken))
    else $error("refusal without a command byte");
  wr_cause_a: assert property (regWrStrobe |-> $past(byteStrobe) && !$past(csN))
    else $error("register write without a taken data byte");
  glb_chan_a: assert property (regWrStrobe && regWrGlobal |-> regWrChan == 4'h0)
    else $error("global write carries channels");
  loc_chan_a: assert property (
    regWrStrobe && !regWrGlobal |-> regWrChan == chanEnable && chanEnable != 4'h0)
    else $error("local write channels differ from enables");
  reg_order_a: assert property (
    regWrStrobe && lastOk_ff |-> regWrAddr[4:2] == lastAddr_ff[4:2]
      && regWrAddr[1:0] < lastAddr_ff[1:0])
    else $error("register addresses do not descend in group");
  en_change_a: assert property (
    $changed(chanEnable) |-> $past(byteStrobe) && !$past(csN))
    else $error("channel enables changed without a data byte");
  idle_out_a: assert property (csN [*3] |-> txByte == 8'h00 && !regWrStrobe)
    else $error("activity while chip select is high");

  cover property (cmdRefused);
  cover property (regWrStrobe && regWrGlobal);
  cover property (regWrStrobe && regWrChan == 4'hf);
endmodule // chd_host_chk

bind chd_host_command_decoder chd_host_chk u_chk (
  .clk(clk), .rst_n(rst_n), .csN(csN), .byteStrobe(byteStrobe), .byteIn(byteIn),
  .txByte(txByte), .regWrStrobe(regWrStrobe), .regWrGlobal(regWrGlobal),
  .regWrChan(regWrChan), .regWrAddr(regWrAddr), .chanEnable(chanEnable),
  .cmdRefused(cmdRefused));

// >>> chd_host_model.sv
// Host side of the control port: frames and byte slots three cycles apart.
// Assumes the decoder samples its inputs on the rising edge of clk.
`timescale 1ns/1ps
module chd_host_model (
  // Clock
  input  wire logic       clk,
  // Host port
  output logic            csN,
  output logic            byteStrobe,
  output logic      [7:0] byteIn,
  input  wire logic [7:0] txByte
);
  initial begin
    csN = 1'b1;
    byteStrobe = 1'b0;
    byteIn = 8'h00;
  end

  // Chip select is held two edges before the first slot and after the last.
  task automatic frame(input logic lvl);
    @(posedge clk);
    csN <= lvl;
    repeat (2) @(posedge clk);
  endtask

  // Returns the byte the decoder shifts out in the same slot.
  task automatic slot(input logic [7:0] b, output logic [7:0] r);
    @(posedge clk);
    byteStrobe <= 1'b1;
    byteIn <= b;
    @(posedge clk);
    r = txByte;
    byteStrobe <= 1'b0;
    byteIn <= ~b;
    @(posedge clk);
  endtask
endmodule // chd_host_model

// >>> testbench.sv
// Self-checking bench of the host command decoder against a reference model.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ps
module testbench;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       csN, byteStrobe, regWrStrobe, regWrGlobal, regRdGlobal, cmdRefused;
  logic [7:0] byteIn, txByte, regWrData, regRdData, hi;
  logic [4:0] regWrAddr, regRdAddr;
  logic [3:0] regWrChan, regRdChan, chanEnable;
  logic [7:0] xl [4][32] = '{default: 8'h00};
  logic [7:0] xg [32] = '{default: 8'h00};
  int         mLoc [4][32] = '{default: 0};
  int         mGlb [32] = '{default: 0};
  int         mCoef [4][40];
  int         mCid [32];
  int         fails = 0, compares = 0, refCnt = 0, seed = 11563;

  always #4 clk = ~clk;

  chd_host_model u_host (.clk(clk), .csN(csN), .byteStrobe(byteStrobe), .byteIn(byteIn),
    .txByte(txByte));
  chd_host_command_decoder u_chd_host_command_decoder (.clk(clk), .rst_n(rst_n),
    .csN(csN), .byteStrobe(byteStrobe), .byteIn(byteIn), .txByte(txByte),
    .regWrStrobe(regWrStrobe), .regWrGlobal(regWrGlobal), .regWrChan(regWrChan),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .regRdAddr(regRdAddr),
    .regRdGlobal(regRdGlobal), .regRdChan(regRdChan), .regRdData(regRdData),
    .chanEnable(chanEnable), .cmdRefused(cmdRefused));

  // External registers written and read back by the decoder.
  always @(posedge clk) begin
    if (regWrStrobe && regWrGlobal) xg[regWrAddr] <= regWrData;
    for (int k = 0; k < 4; k++) if (regWrStrobe && !regWrGlobal && regWrChan[k]) begin
      xl[k][regWrAddr] <= regWrData;
    end
    if (cmdRefused) refCnt++;
  end
  always_comb begin
    if (regRdGlobal) regRdData = xg[regRdAddr];
    else regRdData = xl[regRdChan[3] ? 3 : regRdChan[2] ? 2 : regRdChan[1] ? 1 : 0][regRdAddr];
  end

  task automatic chk(input logic [31:0] got, input int exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  function automatic int low();
    low = 0;
    for (int k = 3; k >= 0; k--) if (mGlb[5][k]) low = k;
  endfunction

  task automatic setEn(input logic [7:0] v);
    logic [7:0] r;
    u_host.frame(1'b0);
    u_host.slot(8'ha5, r);
    u_host.slot(v, r);
    u_host.frame(1'b1);
    mGlb[5] = v;
    chk(chanEnable, v[3:0]);
  endtask

  // One command of cut data slots (full length when negative), checked on reads.
  task automatic run(input logic [7:0] c, input int cut);
    int n, a, w, e, ch;
    logic [7:0] d, r;
    n = (c[6:5] == 2'h3) ? 16 : c[1:0] + 1;
    if (cut >= 0) n = cut;
    ch = low();
    u_host.frame(1'b0);
    u_host.slot(c, r);
    if (!c[7]) u_host.slot(8'h00, r);
    if (!c[7]) chk(r, chd_pkg::ID_CODE);
    for (int i = 0; i < n; i++) begin
      d = $random(seed);
      a = c[4:0] - i;
      w = (c[4] ? c[1:0] : c[3:0]) * 8 + 7 - i / 2;
      u_host.slot(c[7] ? d : 8'h00, r);
      if (c[7] && c[6:5] != 2'h3) begin
        if (c[5]) mGlb[a] = d;
        else for (int k = 0; k < 4; k++) if (mGlb[5][k]) mLoc[k][a] = d;
      end else if (c[7] && i % 2 == 0) begin
        hi = d;
      end else if (c[7] && c[4]) begin
        mCid[w] = {hi, d};
      end else if (c[7]) begin
        for (int k = 0; k < 4; k++) if (mGlb[5][k]) mCoef[k][w] = {hi, d} & 16'hfffc;
      end else begin
        e = (c[6:5] != 2'h3) ? (c[5] ? mGlb[a] : mLoc[ch][a]) : (c[4] ? mCid[w] : mCoef[ch][w]);
        if (c[6:5] == 2'h3) e = (i % 2) ? e & 32'hff : e >> 8;
        chk(r, e);
      end
    end
    u_host.frame(1'b1);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 0, 1);
    close_out();
  end

  // Holds reset for four cycles, then checks that txByte, the register write outputs and the status outputs start at zero.
  task automatic pulseReset();
    logic [31:0] outs;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    mGlb[5] = 0;
    @(posedge clk);
    outs = {txByte, regWrStrobe, regWrGlobal, regWrChan, regWrAddr, regWrData, cmdRefused,
            chanEnable};
    chk(outs, 0);
  endtask

  initial begin
    logic [7:0] bad [5];
    logic [7:0] r;
    int r0;
    bad = '{8'hc0, 8'h45, 8'he5, 8'hf8, 8'hf4};
    pulseReset();
    run(8'h25, -1);
    $display("test reset done");
    setEn(8'h0f);
    run(8'h83, -1);
    for (int k = 0; k < 4; k++) begin
      setEn(8'h01 << k);
      run(8'h03, -1);
    end
    $display("test broadcast done");
    setEn(8'h00);
    run(8'ha2, 1);
    run(8'h22, -1);
    setEn(8'h02);
    run(8'h9f, 2);
    run(8'h1f, -1);
    $display("test abort done");
    setEn(8'h06);
    for (int b = 0; b < 5; b++) run(8'he0 | b, -1);
    for (int k = 1; k < 3; k++) begin
      setEn(8'h01 << k);
      for (int b = 0; b < 5; b++) run(8'h60 | b, -1);
    end
    run(8'he1, 5);
    run(8'h61, -1);
    $display("test coefficient done");
    pulseReset();
    run(8'h25, -1);
    $display("test mid reset done");
    for (int b = 0; b < 4; b++) run(8'hf0 | b, -1);
    for (int b = 0; b < 4; b++) run(8'h70 | b, -1);
    $display("test caller id done");
    foreach (bad[i]) begin
      r0 = refCnt;
      u_host.frame(1'b0);
      u_host.slot(bad[i], r);
      u_host.slot(8'h0f, r);
      u_host.frame(1'b1);
      chk(refCnt - r0, 1);
    end
    setEn(8'h01);
    run(8'h03, -1);
    $display("test refused done");
    close_out();
  end
endmodule // testbench
